// [mdio_core.sv]
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/100ps
// Functional notes
// - Each output terminal carries one selected function
// - Each input terminal assignable to one function
// - Persistent overload raises alarm after set delay
// - Overload warning level 50 to 120 percent
// - Speed attainment band 0 to 400 rpm
// - Initialise restores factory settings, display blinks
// - Increase ratio used only when not 1.00
// - Severe overload or lock alarms within 5s
// - Run while exactly one direction input active
// - Both directions active stops motor instantly
// - Data select inputs pick data number
// - Alarm reset input clears latched alarm
// - External fault input inactive raises alarm, stops
// - Hold release cancels keeping when enabled
// - Primary fault output normally closed, opens on alarm
// - Thirty pulses per revolution, 0.2 ms wide
// - Overload fault output opens on warning/overload alarm
// - Running output active while motor operates
// - Speed reached output when inside band
// - Caution output follows warning, self clearing
// - Function duplicated on terminals acts on any
module mdio_core #(
  parameter int TICK_CYC = mdio_pkg::TICK_CYC
) (
  input  wire logic        sys_clk,           // 20 MHz clock
  input  wire logic        reset_n,           // Async reset
  input  wire logic        psel,              // APB select
  input  wire logic        penable,           // APB enable
  input  wire logic        pwrite,            // APB write
  input  wire logic [7:0]  paddr,             // APB byte address
  input  wire logic [31:0] pwdata,            // APB write data
  output      logic [31:0] prdata,            // APB read data
  output      logic        pready,            // APB ready
  output      logic        pslverr,           // APB error
  input  wire logic        input_terminal_0,  // Input terminal
  input  wire logic        input_terminal_1,  // Input terminal
  input  wire logic        input_terminal_2,  // Input terminal
  output      logic        output_terminal_0, // Output terminal
  output      logic        output_terminal_1, // Output terminal
  input  wire logic        motor_pos_tick,    // 1/30 shaft turn
  input  wire logic        load_over_cont,    // Beyond continuous region
  input  wire logic        load_over_limit,   // Beyond limited region
  input  wire logic        shaft_locked,      // Shaft locked
  input  wire logic [7:0]  load_factor_pct,   // Load factor
  input  wire logic [11:0] speed_meas_rpm,    // Measured speed
  input  wire logic [11:0] speed_set_rpm,     // Speed setpoint
  output      logic        motor_run_out,     // Drive motor
  output      logic        motor_backward_out, // Reverse direction
  output      logic        motor_stop_now,    // Instant stop
  output      logic [1:0]  data_no_out,       // Operation data number
  output      logic        hold_release_out,  // Cancel position keeping
  output      logic [3:0]  alarm_code_out,    // Alarm code to display
  output      logic        display_blink,     // Initialise in progress
  output      logic        ratio_use_increase // Increase ratio in force
);

  // ************************************************
  // Functions
  // ************************************************
  function automatic logic in_any(input logic [2:0] act, input logic [8:0] sel,
                                  input logic [2:0] code, input logic need_act);
    logic r;
    r = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (sel[i*3 +: 3] == code && (act[i] || !need_act)) begin
        r = 1'b1;
      end
    end
    return r;
  endfunction

  function automatic logic out_pick(input logic [2:0] sel, input logic [5:0] f);
    case (sel)
      mdio_pkg::OF_ALARM1:        out_pick = f[0];
      mdio_pkg::OF_SPEED_PULSE:   out_pick = f[1];
      mdio_pkg::OF_ALARM2:        out_pick = f[2];
      mdio_pkg::OF_RUNNING:       out_pick = f[3];
      mdio_pkg::OF_SPEED_REACHED: out_pick = f[4];
      mdio_pkg::OF_CAUTION:       out_pick = f[5];
      default:                    out_pick = 1'b0;
    endcase
  endfunction

  // ************************************************
  // Input conditioning
  // ************************************************
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] act_r;
  logic [1:0] filt_cnt_r [3];

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end else begin
      sync1_r <= {input_terminal_2, input_terminal_1, input_terminal_0};
      sync2_r <= sync1_r;
    end
  end

  // A level must hold FILT_CYC cycles before it is believed
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      act_r <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        filt_cnt_r[i] <= 2'h0;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (sync2_r[i] == act_r[i]) begin
          filt_cnt_r[i] <= 2'h0;
        end else if (filt_cnt_r[i] == 2'(mdio_pkg::FILT_CYC - 1)) begin
          act_r[i]      <= sync2_r[i];
          filt_cnt_r[i] <= 2'h0;
        end else begin
          filt_cnt_r[i] <= filt_cnt_r[i] + 2'h1;
        end
      end
    end
  end

  // ************************************************
  // Configuration registers
  // ************************************************
  logic [5:0]  out_sel_r;
  logic [8:0]  in_sel_r;
  logic [9:0]  ol_time_r;
  logic [6:0]  ol_warn_r;
  logic [8:0]  reach_band_r;
  logic        hold_en_r;
  logic [7:0]  ratio_r;
  mdio_pkg::mdio_state_t state_r;
  logic [3:0]  init_cnt_r;
  logic        wr_en;
  logic        init_done;

  assign wr_en     = psel && penable && pwrite;
  assign init_done = (state_r == mdio_pkg::ST_INIT) && (init_cnt_r == 4'(mdio_pkg::INIT_CYC - 1));

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r    <= mdio_pkg::ST_IDLE;
      init_cnt_r <= 4'h0;
    end else begin
      case (state_r)
        mdio_pkg::ST_IDLE: begin
          if (wr_en && paddr == mdio_pkg::OFS_CTRL && pwdata[mdio_pkg::CTRL_INIT]) begin
            state_r    <= mdio_pkg::ST_INIT;
            init_cnt_r <= 4'h0;
          end
        end
        mdio_pkg::ST_INIT: begin
          init_cnt_r <= init_cnt_r + 4'h1;
          if (init_done) begin
            state_r <= mdio_pkg::ST_IDLE;
          end
        end
        default: state_r <= mdio_pkg::ST_IDLE;
      endcase
    end
  end

  // Writes during initialisation are dropped so the restore is clean
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_sel_r <= mdio_pkg::OUT_SEL_RST;
      in_sel_r  <= mdio_pkg::IN_SEL_RST;
      ol_time_r <= mdio_pkg::OL_TIME_RST;
      ol_warn_r <= mdio_pkg::OL_WARN_RST;
      reach_band_r <= mdio_pkg::REACH_BAND_RST;
      hold_en_r <= 1'b0;
      ratio_r   <= mdio_pkg::RATIO_RST;
    end else if (init_done) begin
      out_sel_r <= mdio_pkg::OUT_SEL_RST;
      in_sel_r  <= mdio_pkg::IN_SEL_RST;
      ol_time_r <= mdio_pkg::OL_TIME_RST;
      ol_warn_r <= mdio_pkg::OL_WARN_RST;
      reach_band_r <= mdio_pkg::REACH_BAND_RST;
      hold_en_r <= 1'b0;
      ratio_r   <= mdio_pkg::RATIO_RST;
    end else if (wr_en && state_r == mdio_pkg::ST_IDLE) begin
      case (paddr)
        mdio_pkg::OFS_OUT_SEL: out_sel_r <= {pwdata[6:4], pwdata[2:0]};
        mdio_pkg::OFS_IN_SEL:  in_sel_r  <= {pwdata[10:8], pwdata[6:4], pwdata[2:0]};
        mdio_pkg::OFS_OL_TIME: begin
          if (pwdata[9:0] < mdio_pkg::OL_TIME_MIN || pwdata[31:10] != 22'h0) begin
            ol_time_r <= (pwdata[31:10] != 22'h0) ? mdio_pkg::OL_TIME_MAX : mdio_pkg::OL_TIME_MIN;
          end else if (pwdata[9:0] > mdio_pkg::OL_TIME_MAX) begin
            ol_time_r <= mdio_pkg::OL_TIME_MAX;
          end else begin
            ol_time_r <= pwdata[9:0];
          end
        end
        mdio_pkg::OFS_OL_WARN: begin
          if (pwdata[31:7] != 25'h0 || pwdata[6:0] > mdio_pkg::OL_WARN_MAX) begin
            ol_warn_r <= mdio_pkg::OL_WARN_MAX;
          end else if (pwdata[6:0] < mdio_pkg::OL_WARN_MIN) begin
            ol_warn_r <= mdio_pkg::OL_WARN_MIN;
          end else begin
            ol_warn_r <= pwdata[6:0];
          end
        end
        mdio_pkg::OFS_REACH_BAND: begin
          if (pwdata[31:9] != 23'h0 || pwdata[8:0] > mdio_pkg::REACH_BAND_MAX) begin
            reach_band_r <= mdio_pkg::REACH_BAND_MAX;
          end else begin
            reach_band_r <= pwdata[8:0];
          end
        end
        mdio_pkg::OFS_CTRL: hold_en_r <= pwdata[mdio_pkg::CTRL_HOLD_EN];
        mdio_pkg::OFS_RATIO: begin
          if (pwdata[31:8] != 24'h0 || pwdata[7:0] > mdio_pkg::RATIO_MAX) begin
            ratio_r <= mdio_pkg::RATIO_MAX;
          end else if (pwdata[7:0] < mdio_pkg::RATIO_UNITY) begin
            ratio_r <= mdio_pkg::RATIO_UNITY;
          end else begin
            ratio_r <= pwdata[7:0];
          end
        end
        default: ;
      endcase
    end
  end

  // ************************************************
  // Input functions
  // ************************************************
  logic run_forward_in;
  logic run_reverse_in;
  logic data_select_bit0;
  logic data_select_bit1;
  logic alarm_reset_in;
  logic external_fault_in;
  logic ext_assigned;
  logic hold_release_in;
  logic ext_fault;

  always_comb begin
    run_forward_in    = in_any(act_r, in_sel_r, mdio_pkg::IF_RUN_FORWARD, 1'b1);
    run_reverse_in    = in_any(act_r, in_sel_r, mdio_pkg::IF_RUN_REVERSE, 1'b1);
    data_select_bit0  = in_any(act_r, in_sel_r, mdio_pkg::IF_DATA_SEL0, 1'b1);
    data_select_bit1  = in_any(act_r, in_sel_r, mdio_pkg::IF_DATA_SEL1, 1'b1);
    alarm_reset_in    = in_any(act_r, in_sel_r, mdio_pkg::IF_ALARM_RESET, 1'b1);
    external_fault_in = in_any(act_r, in_sel_r, mdio_pkg::IF_EXT_FAULT, 1'b1);
    ext_assigned      = in_any(act_r, in_sel_r, mdio_pkg::IF_EXT_FAULT, 1'b0);
    hold_release_in   = in_any(act_r, in_sel_r, mdio_pkg::IF_HOLD_RELEASE, 1'b1);
  end

  // Normally closed: an open terminal is the fault
  assign ext_fault = ext_assigned && !external_fault_in;

  // ************************************************
  // Overload timing
  // ************************************************
  logic [20:0] tick_cnt_r;
  logic        tick;
  logic [9:0]  ol_cnt_r;
  logic [9:0]  ol_lim;
  logic        ol_cond;
  logic        ol_severe;
  logic        ol_trip;
  logic        alarm_r;
  logic [3:0]  alarm_code_r;

  assign tick      = (tick_cnt_r == 21'(TICK_CYC - 1));
  assign ol_severe = load_over_limit || shaft_locked;
  assign ol_cond   = load_over_cont || ol_severe;
  assign ol_lim    = (ol_severe && ol_time_r > 10'(mdio_pkg::SEVERE_TICKS)) ?
                     10'(mdio_pkg::SEVERE_TICKS) : ol_time_r;
  assign ol_trip   = ol_cond && (ol_cnt_r >= ol_lim);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_r <= 21'h0;
    end else if (tick) begin
      tick_cnt_r <= 21'h0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 21'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ol_cnt_r <= 10'h0;
    end else if (!ol_cond || alarm_r) begin
      ol_cnt_r <= 10'h0;
    end else if (tick && ol_cnt_r < ol_lim) begin
      ol_cnt_r <= ol_cnt_r + 10'h1;
    end
  end

  // An external fault still present wins over a reset arriving in the same cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      alarm_r      <= 1'b0;
      alarm_code_r <= mdio_pkg::ALM_NONE;
    end else if (ext_fault && !alarm_r) begin
      alarm_r      <= 1'b1;
      alarm_code_r <= mdio_pkg::ALM_EXTERNAL;
    end else if (ol_trip && !alarm_r) begin
      alarm_r      <= 1'b1;
      alarm_code_r <= mdio_pkg::ALM_OVERLOAD;
    end else if (alarm_r && alarm_reset_in && !ext_fault) begin
      alarm_r      <= 1'b0;
      alarm_code_r <= mdio_pkg::ALM_NONE;
    end
  end

  // ************************************************
  // Motor control and status
  // ************************************************
  logic warn_r;
  logic reached_r;
  logic [11:0] spd_diff;
  logic [11:0] pw_cnt_r;
  logic spd_pulse_r;

  assign spd_diff = (speed_meas_rpm > speed_set_rpm) ? speed_meas_rpm - speed_set_rpm
                                                     : speed_set_rpm - speed_meas_rpm;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      motor_run_out    <= 1'b0;
      motor_backward_out <= 1'b0;
      motor_stop_now   <= 1'b0;
      data_no_out      <= 2'h0;
      hold_release_out <= 1'b0;
      ratio_use_increase <= 1'b0;
    end else begin
      motor_run_out    <= (run_forward_in ^ run_reverse_in) && !alarm_r && !ext_fault;
      motor_backward_out <= run_reverse_in && !run_forward_in;
      motor_stop_now   <= (run_forward_in && run_reverse_in) || ext_fault || alarm_r;
      data_no_out      <= {data_select_bit1, data_select_bit0};
      hold_release_out <= hold_en_r && hold_release_in;
      ratio_use_increase <= (ratio_r != mdio_pkg::RATIO_UNITY);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      warn_r    <= 1'b0;
      reached_r <= 1'b0;
    end else begin
      warn_r    <= (load_factor_pct >= {1'b0, ol_warn_r});
      reached_r <= motor_run_out && (spd_diff <= {3'h0, reach_band_r});
    end
  end

  // A tick inside a running pulse is absorbed; at the top speed the
  // tick spacing stays well above the pulse width
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      spd_pulse_r <= 1'b0;
      pw_cnt_r    <= 12'h0;
    end else if (spd_pulse_r) begin
      if (pw_cnt_r == 12'(mdio_pkg::SPD_PULSE_CYC - 1)) begin
        spd_pulse_r <= 1'b0;
        pw_cnt_r    <= 12'h0;
      end else begin
        pw_cnt_r <= pw_cnt_r + 12'h1;
      end
    end else if (motor_pos_tick) begin
      spd_pulse_r <= 1'b1;
    end
  end

  // ************************************************
  // Output terminals
  // ************************************************
  logic fault_out_primary;
  logic overload_fault_out;
  logic speed_reached_out;
  logic caution_out;

  assign fault_out_primary  = !alarm_r;
  assign overload_fault_out = !(warn_r || (alarm_r && alarm_code_r == mdio_pkg::ALM_OVERLOAD));
  assign speed_reached_out  = reached_r;
  assign caution_out        = warn_r;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      output_terminal_0 <= 1'b0;
      output_terminal_1 <= 1'b0;
    end else begin
      output_terminal_0 <= out_pick(out_sel_r[2:0], {caution_out, speed_reached_out, motor_run_out,
                                    overload_fault_out, spd_pulse_r, fault_out_primary});
      output_terminal_1 <= out_pick(out_sel_r[5:3], {caution_out, speed_reached_out, motor_run_out,
                                    overload_fault_out, spd_pulse_r, fault_out_primary});
    end
  end

  assign alarm_code_out = alarm_code_r;
  assign display_blink  = (state_r == mdio_pkg::ST_INIT);

  // ************************************************
  // APB slave
  // ************************************************
  assign pready  = 1'b1;
  assign pslverr = psel && penable && (paddr[1:0] != 2'h0 || paddr > mdio_pkg::OFS_STATUS);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      case (paddr)
        mdio_pkg::OFS_OUT_SEL: prdata <= {25'h0, out_sel_r[5:3], 1'b0, out_sel_r[2:0]};
        mdio_pkg::OFS_IN_SEL:  prdata <= {21'h0, in_sel_r[8:6], 1'b0, in_sel_r[5:3], 1'b0, in_sel_r[2:0]};
        mdio_pkg::OFS_OL_TIME: prdata <= {22'h0, ol_time_r};
        mdio_pkg::OFS_OL_WARN: prdata <= {25'h0, ol_warn_r};
        mdio_pkg::OFS_REACH_BAND: prdata <= {23'h0, reach_band_r};
        mdio_pkg::OFS_CTRL:    prdata <= {31'h0, hold_en_r};
        mdio_pkg::OFS_RATIO:   prdata <= {24'h0, ratio_r};
        mdio_pkg::OFS_STATUS:  prdata <= {13'h0, act_r, display_blink, hold_release_out, reached_r, warn_r,
                                          data_no_out, motor_backward_out, motor_run_out, alarm_code_r, 3'h0, alarm_r};
        default:               prdata <= 32'h0;
      endcase
    end
  end

  // ************************************************
  // Assertions
  // ************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  AST_BOTH_STOP: assert property ((run_forward_in && run_reverse_in) |=> !motor_run_out && motor_stop_now)
    else $error("both directions did not stop motor");
  AST_ONE_RUNS: assert property (motor_run_out |-> $past(run_forward_in ^ run_reverse_in))
    else $error("motor ran without a single direction");
  AST_DATA_NO: assert property (1'b1 |=> data_no_out == $past({data_select_bit1, data_select_bit0}))
    else $error("data number mismatch");
  AST_EXT_ALARM: assert property (ext_fault |=> alarm_r && !motor_run_out)
    else $error("external fault not alarmed");
  AST_ALARM_OUT: assert property ((out_sel_r[5:3] == mdio_pkg::OF_ALARM1 && alarm_r) |=>
                                  !output_terminal_1)
    else $error("primary fault terminal not open on alarm");
  AST_SEVERE: assert property ((ol_severe && !alarm_r && ol_cnt_r >= 10'(mdio_pkg::SEVERE_TICKS)) |=>
                               alarm_r)
    else $error("severe overload not alarmed in time");
  AST_OL_TRIP: assert property ((ol_cond && !ext_fault && !alarm_r && ol_cnt_r >= ol_lim) |=>
                                alarm_r && alarm_code_r == mdio_pkg::ALM_OVERLOAD)
    else $error("overload alarm missed");
  AST_PULSE_W: assert property ($fell(spd_pulse_r) |-> $past(pw_cnt_r) == 12'(mdio_pkg::SPD_PULSE_CYC - 1))
    else $error("speed pulse width wrong");
  AST_WARN: assert property ((load_factor_pct >= {1'b0, ol_warn_r}) |=> warn_r && !overload_fault_out)
    else $error("overload warning not shown");
  AST_RESET_CLR: assert property ((alarm_r && alarm_reset_in && !ext_fault) |=> !alarm_r)
    else $error("alarm reset ignored");
  AST_INIT: assert property (init_done |=> out_sel_r == mdio_pkg::OUT_SEL_RST &&
                             ol_time_r == mdio_pkg::OL_TIME_RST && !display_blink)
    else $error("initialise did not restore settings");
  AST_RATIO: assert property ($changed(ratio_r) |=> ratio_use_increase == (ratio_r != mdio_pkg::RATIO_UNITY))
    else $error("ratio selection wrong");

  COV_RUN_FWD: cover property (run_forward_in && !run_reverse_in ##1 motor_run_out);
  COV_EXT: cover property (ext_fault ##1 alarm_r ##[1:20] alarm_reset_in);
  COV_INIT: cover property (display_blink ##1 init_done);

endmodule

// [mdio_pkg.sv]
package mdio_pkg;
  // ************************************************
  // Timing
  // ************************************************
  localparam int CLK_HZ          = 20_000_000;
  localparam int SPD_PULSE_US    = 200;
  localparam int SPD_PULSE_CYC   = SPD_PULSE_US * (CLK_HZ / 1_000_000);
  localparam int TICK_MS         = 100;
  localparam int TICK_CYC        = TICK_MS * (CLK_HZ / 1000);
  localparam int SEVERE_S        = 5;
  localparam int SEVERE_TICKS    = SEVERE_S * 1000 / TICK_MS;
  localparam int FILT_CYC        = 4;
  localparam int INIT_CYC        = 16;

  // ************************************************
  // Register map
  // ************************************************
  localparam logic [7:0] OFS_OUT_SEL  = 8'h00;
  localparam logic [7:0] OFS_IN_SEL   = 8'h04;
  localparam logic [7:0] OFS_OL_TIME  = 8'h08;
  localparam logic [7:0] OFS_OL_WARN  = 8'h0c;
  localparam logic [7:0] OFS_REACH_BAND = 8'h10;
  localparam logic [7:0] OFS_CTRL     = 8'h14;
  localparam logic [7:0] OFS_RATIO    = 8'h18;
  localparam logic [7:0] OFS_STATUS   = 8'h1c;

  localparam int CTRL_HOLD_EN = 0;
  localparam int CTRL_INIT    = 1;

  localparam logic [9:0]  OL_TIME_MIN  = 10'h001;
  localparam logic [9:0]  OL_TIME_MAX  = 10'h258;
  localparam logic [9:0]  OL_TIME_RST  = 10'h12c;
  localparam logic [6:0]  OL_WARN_MIN  = 7'h32;
  localparam logic [6:0]  OL_WARN_MAX  = 7'h78;
  localparam logic [6:0]  OL_WARN_RST  = 7'h78;
  localparam logic [8:0]  REACH_BAND_MAX = 9'h190;
  localparam logic [8:0]  REACH_BAND_RST = 9'h0c8;
  localparam logic [7:0]  RATIO_UNITY  = 8'h64;
  localparam logic [7:0]  RATIO_MAX    = 8'hc8;
  localparam logic [7:0]  RATIO_RST    = 8'h64;

  localparam logic [3:0]  ALM_NONE     = 4'h0;
  localparam logic [3:0]  ALM_OVERLOAD = 4'h1;
  localparam logic [3:0]  ALM_EXTERNAL = 4'h2;

  typedef enum logic [2:0] {
    OF_NONE          = 3'b000,
    OF_ALARM1        = 3'b001,
    OF_SPEED_PULSE   = 3'b010,
    OF_ALARM2        = 3'b011,
    OF_RUNNING       = 3'b100,
    OF_SPEED_REACHED = 3'b101,
    OF_CAUTION       = 3'b110
  } mdio_ofunc_t;

  typedef enum logic [2:0] {
    IF_NONE          = 3'b000,
    IF_RUN_FORWARD   = 3'b001,
    IF_RUN_REVERSE   = 3'b010,
    IF_DATA_SEL0     = 3'b011,
    IF_DATA_SEL1     = 3'b100,
    IF_ALARM_RESET   = 3'b101,
    IF_EXT_FAULT     = 3'b110,
    IF_HOLD_RELEASE  = 3'b111
  } mdio_ifunc_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_INIT = 1'b1
  } mdio_state_t;

  localparam logic [5:0] OUT_SEL_RST = {OF_ALARM1, OF_SPEED_PULSE};
  localparam logic [8:0] IN_SEL_RST  = {IF_DATA_SEL0, IF_RUN_REVERSE, IF_RUN_FORWARD};
endpackage

// [mdio_ctl_model.sv]
`timescale 1ns/100ps
module mdio_ctl_model (
  input  wire logic       sys_clk,  // Clock
  input  wire logic [2:0] want,     // Requested terminal levels
  input  wire logic       pulse_in, // Speed pulse terminal
  output      logic [2:0] term,     // Driven terminals
  output      int         width     // Last pulse width, cycles
);
  int run;
  initial begin
    term = 3'h0;
    width = 0;
    run = 0;
  end
  // Terminals move just after an edge; one function per terminal
  always @(posedge sys_clk) begin
    term <= want;
    if (pulse_in) begin
      run <= run + 1;
    end else if (run != 0) begin
      width <= run;
      run <= 0;
    end
  end
endmodule

// [motor_driver_io_function_logic_tb_top.sv]
`timescale 1ns/100ps
module motor_driver_io_function_logic_tb_top;
  logic sys_clk, reset_n, psel, penable, pwrite, pready, pslverr, err, tick, lc;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [2:0] want, term;
  logic out_t0, out_t1, run, bwd, stp, blink, incr, sev;
  logic [1:0] dno;
  logic [3:0] alm;
  logic [7:0] lf;
  int width, bad_count, comparisons, cycles;
  logic [7:0] ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18};
  logic [31:0] rv[6] = '{32'h12, 32'h321, 32'h12c, 32'h78, 32'hc8, 32'h64};
  mdio_core #(.TICK_CYC(10)) mdio_core_i (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .input_terminal_0(term[0]), .input_terminal_1(term[1]),
    .input_terminal_2(term[2]), .output_terminal_0(out_t0), .output_terminal_1(out_t1),
    .motor_pos_tick(tick), .load_over_cont(lc), .load_over_limit(1'b0), .shaft_locked(sev),
    .load_factor_pct(lf), .speed_meas_rpm(12'h000), .speed_set_rpm(12'h000),
    .motor_run_out(run), .motor_backward_out(bwd), .motor_stop_now(stp), .data_no_out(dno),
    .hold_release_out(), .alarm_code_out(alm), .display_blink(blink), .ratio_use_increase(incr));
  mdio_ctl_model mdio_ctl_model_i (.sys_clk(sys_clk), .want(want), .pulse_in(out_t0), .term(term),
    .width(width));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so back-to-back calls never drive psel twice in a step
    @(posedge sys_clk);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard: the sequence needs about 5000 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    {reset_n, psel, penable, pwrite, paddr, pwdata, want, tick, lc, sev, lf} = '0;
    cyc(5);
    reset_n <= 1'b1;
    cyc(1);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk("factory", rv[i], q);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h1, {q[30:0], err});
    want <= 3'b001;
    cyc(12);
    chk("run", 1, {bwd, run});
    want <= 3'b011;
    cyc(12);
    chk("stop", 2'b10, {stp, run});
    want <= 3'b100;
    apb(1'b1, 8'h08, 32'h3);
    lc <= 1'b1;
    cyc(12);
    chk("early", 0, alm);
    chk("datano", 1, dno);
    cyc(40);
    chk("overload", 5'h02, {alm, out_t1});
    lc <= 1'b0;
    apb(1'b1, 8'h04, 32'h605);
    want <= 3'b101;
    cyc(12);
    chk("reset", 5'h01, {alm, out_t1});
    want <= 3'b000;
    cyc(12);
    chk("extfault", 5'h05, {alm, stp});
    want <= 3'b101;
    cyc(12);
    chk("reset2", 0, alm);
    tick <= 1'b1;
    cyc(1);
    tick <= 1'b0;
    cyc(4100);
    chk("pulse", mdio_pkg::SPD_PULSE_CYC, width);
    apb(1'b1, 8'h00, 32'h36);
    lf <= 8'h78;
    cyc(3);
    chk("caution", 2'b10, {out_t0, out_t1});
    lf <= 8'h77;
    cyc(3);
    chk("cleared", 2'b01, {out_t0, out_t1});
    apb(1'b1, 8'h18, 32'h96);
    cyc(2);
    chk("incr", 1, incr);
    apb(1'b1, 8'h18, 32'h64);
    cyc(2);
    chk("unity", 0, incr);
    apb(1'b1, 8'h14, 32'h2);
    cyc(2);
    chk("blink", 1, blink);
    cyc(20);
    apb(1'b0, 8'h08, 32'h0);
    chk("restored", 32'h12c, q);
    // Locked shaft must trip after 50 ticks although the delay is back at 300
    sev <= 1'b1;
    cyc(400);
    chk("notyet", 0, alm);
    cyc(120);
    chk("severe", 1, alm);
    end_sim();
  end
endmodule
